// ### include/ctc_pkg.sv
// Purpose: shared constants and types for the calibration and test control block
// Assumes: 10 MHz system clock, APB with 32-bit data
// Notes: register byte addresses are index times four
package ctc_pkg;
  localparam int unsigned CTC_CLK_HZ = 10000000;
  localparam int unsigned CTC_DCU_TIME_NS = 6000;
  localparam int unsigned CTC_TUNE_TIME_NS = 25000;
  localparam int unsigned CTC_DCU_CYCLES = CTC_DCU_TIME_NS / (1000000000 / CTC_CLK_HZ);
  localparam int unsigned CTC_TUNE_CYCLES = CTC_TUNE_TIME_NS / (1000000000 / CTC_CLK_HZ);

  localparam logic [7:0] CTC_IDX_TUNE = 8'h18;
  localparam logic [7:0] CTC_IDX_DCU = 8'h1b;
  localparam logic [7:0] CTC_IDX_TST = 8'h3d;
  localparam logic [7:0] CTC_IDX_STATUS = 8'h3e;

  localparam int CTC_GO_BIT = 7;
  localparam int CTC_CHIP_MAN_BIT = 7;
  localparam int CTC_CHIP_LVL_BIT = 6;
  localparam int CTC_DIR_BIT = 5;
  localparam int CTC_DIR_SEL_BIT = 4;
  localparam int CTC_TUNEV_LSB = 0;
  localparam int CTC_TUNEV_W = 6;

  localparam logic [6:0] CTC_TUNE_RST = 7'h58;
  localparam logic [6:0] CTC_DCU_RST = 7'h20;
  localparam logic [7:0] CTC_TST_RST = 8'h00;

  typedef struct packed {
    logic chip_manual;
    logic chip_level;
    logic dir_manual;
    logic dir_tx;
  } ctc_test_s;
endpackage

// ### design/ctc_cal_timer.sv
// Purpose: one-shot calibration timer
// Assumes: start is a one-cycle pulse
// Notes: busy stays high for CYCLES clocks after start
`timescale 1ns/10ps
module ctc_cal_timer #(
  parameter int unsigned CYCLES = 60
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  initial begin
    if (CYCLES < 1) $error("cycles must be at least one");
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start && cnt_reg == '0) begin
      cnt_reg <= CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

// ### design/ctc_top.sv
// Purpose: calibration trigger and test modulation control registers over APB
// Assumes: single clock, power-up events arrive as same-domain pulses
// Notes: zero wait state APB slave
// Operation
// - writing one to the delay-cell go bit runs a 6 us cycle and the bit reads one meanwhile.
// - each go bit clears itself once its calibration cycle has ended.
// - writing one to the filter-tuning go bit runs a 25 us cycle, then the bit drops to zero.
// - entering the idle state from power-on, sleep, deepest_power_down_state or reset starts filter tuning.
// - test bits are always read/write but act only while the power monitor is enabled.
// - the chip source select bit picks normal data or the forced chip level.
// - the forced chip level gives continuous zero chips or one chips.
// - the direction select bit enables manual choice of synthesizer frequency.
// - in manual mode the direction bit picks receive at zero and transmit at one.
// - the filter tune value is six bits, resets to 0x18 and drives the tuning loops.
`timescale 1ns/10ps
module ctc_top
  import ctc_pkg::*;
#(
  parameter int unsigned DCU_CYCLES = CTC_DCU_CYCLES,
  parameter int unsigned TUNE_CYCLES = CTC_TUNE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_monitor_enable,
  input wire logic idle_entry_from_power_down,
  input wire logic normal_chip,
  input wire logic normal_dir_tx,
  output logic modulation_chip,
  output logic synth_dir_tx,
  output logic [CTC_TUNEV_W-1:0] filter_tune_value,
  output logic delay_cell_cal_busy,
  output logic filter_tuning_busy
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic access;
  logic wr;
  logic [7:0] idx;
  logic hit_tune;
  logic hit_dcu;
  logic hit_tst;
  logic hit_sts;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign idx = paddr[9:2];
  assign hit_tune = (paddr[31:10] == '0) && (paddr[1:0] == 2'h0) && (idx == CTC_IDX_TUNE);
  assign hit_dcu = (paddr[31:10] == '0) && (paddr[1:0] == 2'h0) && (idx == CTC_IDX_DCU);
  assign hit_tst = (paddr[31:10] == '0) && (paddr[1:0] == 2'h0) && (idx == CTC_IDX_TST);
  assign hit_sts = (paddr[31:10] == '0) && (paddr[1:0] == 2'h0) && (idx == CTC_IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !(hit_tune || hit_dcu || hit_tst || hit_sts);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [6:0] tune_reg;
  logic [6:0] dcu_reg;
  logic [7:0] tst_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_reg <= CTC_TUNE_RST;
    end else if (wr && hit_tune) begin
      tune_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcu_reg <= CTC_DCU_RST;
    end else if (wr && hit_dcu) begin
      // bit 6 is read-only zero
      dcu_reg <= {1'b0, pwdata[5:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tst_reg <= CTC_TST_RST;
    end else if (wr && hit_tst) begin
      tst_reg <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // calibration timers
  // ---------------------------------------------------------------
  logic dcu_start;
  logic tune_start;

  // a zero in the go bit starts nothing
  assign dcu_start = wr && hit_dcu && pwdata[CTC_GO_BIT];
  assign tune_start = (wr && hit_tune && pwdata[CTC_GO_BIT])
    || idle_entry_from_power_down;

  // busy doubles as the go bit readback, clearing at cycle end
  ctc_cal_timer #(
    .CYCLES(DCU_CYCLES)
  ) u_dcu_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(dcu_start),
    .busy(delay_cell_cal_busy)
  );

  ctc_cal_timer #(
    .CYCLES(TUNE_CYCLES)
  ) u_tune_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(tune_start),
    .busy(filter_tuning_busy)
  );

  // ---------------------------------------------------------------
  // test controls
  // ---------------------------------------------------------------
  ctc_test_s eff;
  logic chip_next;
  logic dir_next;
  logic chip_reg;
  logic dir_reg;
  logic [CTC_TUNEV_W-1:0] tunev_reg;

  always_comb begin
    if (power_monitor_enable) begin
      eff.chip_manual = tst_reg[CTC_CHIP_MAN_BIT];
      eff.chip_level = tst_reg[CTC_CHIP_LVL_BIT];
      eff.dir_manual = tst_reg[CTC_DIR_SEL_BIT];
      eff.dir_tx = tst_reg[CTC_DIR_BIT];
    end else begin
      eff.chip_manual = CTC_TST_RST[CTC_CHIP_MAN_BIT];
      eff.chip_level = CTC_TST_RST[CTC_CHIP_LVL_BIT];
      eff.dir_manual = CTC_TST_RST[CTC_DIR_SEL_BIT];
      eff.dir_tx = CTC_TST_RST[CTC_DIR_BIT];
    end
  end

  assign chip_next = eff.chip_manual ? eff.chip_level : normal_chip;
  assign dir_next = eff.dir_manual ? eff.dir_tx : normal_dir_tx;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      chip_reg <= chip_next;
      dir_reg <= dir_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tunev_reg <= CTC_TUNE_RST[CTC_TUNEV_W-1:0];
    end else begin
      tunev_reg <= tune_reg[CTC_TUNEV_LSB +: CTC_TUNEV_W];
    end
  end

  assign modulation_chip = chip_reg;
  assign synth_dir_tx = dir_reg;
  assign filter_tune_value = tunev_reg;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_tune) begin
      rdata_next[7:0] = {filter_tuning_busy, tune_reg};
    end else if (hit_dcu) begin
      rdata_next[7:0] = {delay_cell_cal_busy, dcu_reg};
    end else if (hit_tst) begin
      rdata_next[7:0] = tst_reg;
    end else if (hit_sts) begin
      rdata_next[1:0] = {filter_tuning_busy, delay_cell_cal_busy};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
endmodule

// ### bench/ctc_checker.sv
// Purpose: port-level assertions for the calibration and test control block
// Assumes: single clock domain, byte address is index times four
// Notes: bound onto ctc_top from the testbench top file
`timescale 1ns/10ps
module ctc_checker
  import ctc_pkg::*;
#(
  parameter int unsigned DCU_CYCLES = 3,
  parameter int unsigned TUNE_CYCLES = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic power_monitor_enable,
  input wire logic idle_entry_from_power_down,
  input wire logic normal_chip,
  input wire logic normal_dir_tx,
  input wire logic modulation_chip,
  input wire logic synth_dir_tx,
  input wire logic [CTC_TUNEV_W-1:0] filter_tune_value,
  input wire logic delay_cell_cal_busy,
  input wire logic filter_tuning_busy
);
  wire apb_wr = psel && penable && pwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_dcu_go_start: assert property (apb_wr && paddr == 32'h6c && pwdata[7]
    && !delay_cell_cal_busy |-> ##[1:2] delay_cell_cal_busy) else $error("dcu not started");
  a_dcu_go_clear: assert property ($rose(delay_cell_cal_busy)
    |-> ##DCU_CYCLES $fell(delay_cell_cal_busy)) else $error("dcu length wrong");
  a_tune_go_clear: assert property ($rose(filter_tuning_busy)
    |-> ##TUNE_CYCLES $fell(filter_tuning_busy)) else $error("tuning length wrong");
  a_auto_tune: assert property (idle_entry_from_power_down && !filter_tuning_busy
    |-> ##[1:2] filter_tuning_busy) else $error("no automatic tuning");
  a_zero_go: assert property (apb_wr && paddr == 32'h6c && !pwdata[7] && !delay_cell_cal_busy
    |=> !delay_cell_cal_busy ##1 !delay_cell_cal_busy) else $error("zero write started dcu");
  a_pme_off: assert property (!power_monitor_enable ##1 !power_monitor_enable
    |-> modulation_chip == $past(normal_chip) && synth_dir_tx == $past(normal_dir_tx))
    else $error("test bits acted without power monitor");
  a_tune_copy: assert property (apb_wr && paddr == 32'h60
    |-> ##2 filter_tune_value == 6'($past(pwdata, 2))) else $error("tune value not copied");
  a_bad_addr: assert property (psel && penable
    && !(paddr inside {32'h60, 32'h6c, 32'hf4, 32'hf8}) |-> pslverr) else $error("no slverr");
endmodule

// ### bench/tb_top.sv
// Purpose: directed register tests for the calibration and test control block
// Assumes: short calibration counts of 3 and 5 cycles
// Notes: apb master waits on pready, watchdog ends a hang
`timescale 1ns/10ps
module tb_top;
  import ctc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, modulation_chip, synth_dir_tx, delay_cell_cal_busy, filter_tuning_busy;
  logic power_monitor_enable = 1'b0, idle_entry_from_power_down = 1'b0;
  logic normal_chip = 1'b0, normal_dir_tx = 1'b0;
  logic [CTC_TUNEV_W-1:0] filter_tune_value;
  logic [7:0] tv [5] = '{8'h80, 8'hc0, 8'h10, 8'h30, 8'h00};
  logic [3:0] tx [5] = '{4'b1101, 4'b0010, 4'b1110, 4'b0001, 4'b1010};
  int err_count = 0, n_checks = 0;
  ctc_top #(.DCU_CYCLES(3), .TUNE_CYCLES(5)) ctc_top_i (.*);
  always #50 sys_clk = ~sys_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(32'h60, 32'h58);
    rdc(32'h6c, 32'h20);
    rdc(32'hf4, 32'h00);
    wr(32'h6c, 32'h80);
    rdc(32'h6c, 32'h80);
    repeat (6) @(posedge sys_clk);
    rdc(32'h6c, 32'h00);
    wr(32'h6c, 32'h7f);
    rdc(32'h6c, 32'h3f);
    $display("dcu test done");
    wr(32'h60, 32'hbf);
    rdc(32'h60, 32'hbf);
    chk(32'(filter_tune_value), 32'h3f);
    repeat (8) @(posedge sys_clk);
    rdc(32'h60, 32'h3f);
    idle_entry_from_power_down <= 1'b1;
    @(posedge sys_clk) idle_entry_from_power_down <= 1'b0;
    @(posedge sys_clk);
    rdc(32'hf8, 32'h02);
    $display("tuning test done");
    normal_chip <= 1'b1;
    wr(32'hf4, 32'hf0);
    @(posedge sys_clk);
    chk(32'({modulation_chip, synth_dir_tx}), 32'h2);
    rdc(32'hf4, 32'hf0);
    power_monitor_enable <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      normal_chip <= tx[i][3];
      normal_dir_tx <= tx[i][2];
      wr(32'hf4, 32'(tv[i]));
      @(posedge sys_clk);
      chk(32'({modulation_chip, synth_dir_tx}), 32'(tx[i][1:0]));
    end
    apb(1'b0, 32'h64, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("test register done");
    conclude;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    conclude;
  end
endmodule
bind ctc_top ctc_checker #(.DCU_CYCLES(DCU_CYCLES), .TUNE_CYCLES(TUNE_CYCLES)) ctc_checker_i (.*);
